// *** hshp_defs.svh ***
// Purpose: constants of the serial and host pin block
// Assumes: included by its bare name
// Notes: register offsets follow the four-bit register select code
`ifndef HSHP_DEFS_SVH
`define HSHP_DEFS_SVH

// ----------------------------------------
// register select codes
// ----------------------------------------
`define HSHP_ADDR_FIFO_STAT 4'h0
`define HSHP_ADDR_DATA 4'h1
`define HSHP_ADDR_CONTROL 4'h2
`define HSHP_ADDR_RX_ADDR 4'h3
`define HSHP_ADDR_CC_TX 4'h4
`define HSHP_ADDR_TIMING 4'h5
`define HSHP_ADDR_FLAG_WDOG 4'h6
`define HSHP_ADDR_INT_EN 4'h7
`define HSHP_ADDR_GEN_STAT 4'h8
`define HSHP_ADDR_CC_RX 4'h9

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define HSHP_TIM_INTERNAL 0
`define HSHP_TIM_RATE_SEL 1
`define HSHP_FLG_TX_DONE 0
`define HSHP_FLG_RX_BYTE 1
`define HSHP_FLG_WDOG 2
`define HSHP_FST_TX_BUSY 0
`define HSHP_FST_RX_FULL 1
`define HSHP_REG_RESET 8'h00
`define HSHP_IDLE_BYTE 8'hff

// ----------------------------------------
// frame timing
// ----------------------------------------
`define HSHP_LAST_SLOT 6'h04
`define HSHP_CC_SLOT 6'h01
`define HSHP_SLOTS_PER_FRAME 6'h20

`endif

// *** hshp_pkg.sv ***
// Purpose: types of the serial and host pin block
// Assumes: nothing
// Notes: constants live in hshp_defs.svh
package hshp_pkg;

	typedef logic [7:0] hshp_byte_t;
	typedef logic [3:0] hshp_addr_t;

	// host access sequencer, gray along idle -> active -> done
	typedef enum logic [1:0] {
		HSHP_ACC_IDLE = 2'b00,
		HSHP_ACC_ACTIVE = 2'b01,
		HSHP_ACC_DONE = 2'b11
	} hshp_acc_t;

endpackage : hshp_pkg

// *** hshp_sync.sv ***
// Purpose: two flip-flop synchroniser for levels and toggles
// Assumes: each bit is independent
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module hshp_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// no reset: also used to bring the reset itself into the link domain
	always_ff @(posedge clk) begin
		meta_reg <= async_in;
		sync_out <= meta_reg;
	end

endmodule : hshp_sync

// *** hshp_link.sv ***
// Purpose: serial side, clocked by the line clock
// Assumes: gates and frame pulse are timed by the line clock
// Notes: words cross to the system clock by toggle handshakes
`timescale 1ns/1ns
`include "hshp_defs.svh"
module hshp_link (
	input wire logic line_clock,
	input wire logic rst_n,
	input wire logic internal_mode,
	input wire logic line_clock_rate_sel,
	input wire logic frame_pulse_n,
	input wire logic tx_clock_gate_n,
	input wire logic rx_clock_gate_n,
	input wire logic serial_line_in,
	input wire logic tx_req_tgl,
	input wire logic [7:0] tx_data,
	input wire logic [7:0] cc_data,
	output logic tx_ack_tgl,
	output logic rx_tgl,
	output logic [7:0] rx_data,
	output logic [7:0] rx_cc_data,
	output logic serial_line_out,
	output logic serial_line_oe_n
);

	logic [3:0] ctl_s;
	logic link_rst_n, int_s, dbl_s, req_s;
	logic phase_reg, rx_phase_reg, pend_valid_reg, req_seen_reg;
	logic [2:0] tx_idx_reg, rx_idx_reg;
	logic [5:0] tx_slot_reg, rx_slot_reg;
	logic [7:0] tx_shift_reg, pend_reg, pend_cc_reg, rx_shift_reg;
	logic tx_step, rx_step, tx_slot_ok, rx_slot_ok;

	hshp_sync #(.WIDTH(4)) u_sync (
		.clk(line_clock),
		.async_in({rst_n, internal_mode, line_clock_rate_sel, tx_req_tgl}),
		.sync_out(ctl_s)
	);
	assign {link_rst_n, int_s, dbl_s, req_s} = ctl_s;

	// slot index advances after the eighth bit of a slot
	function automatic logic [5:0] next_slot(input logic [2:0] idx, input logic [5:0] slot);
		next_slot = (idx == 3'h7) ? ((slot == `HSHP_SLOTS_PER_FRAME - 6'h01) ? 6'h00 :
			slot + 6'h01) : slot;
	endfunction : next_slot

	// ----------------------------------------
	// transmit, changes on the rising edge
	// ----------------------------------------
	assign tx_slot_ok = tx_slot_reg <= `HSHP_LAST_SLOT;
	// internal: gates ignored, double rate halves the bit rate
	assign tx_step = int_s ? (!dbl_s || phase_reg) : !tx_clock_gate_n;

	always_ff @(posedge line_clock) begin
		if (!link_rst_n || !frame_pulse_n || !int_s) begin
			phase_reg <= 1'b0;
		end else begin
			phase_reg <= !phase_reg;
		end
	end

	always_ff @(posedge line_clock) begin
		if (!link_rst_n) begin
			tx_idx_reg <= 3'h0;
			tx_slot_reg <= 6'h00;
		end else if (int_s && !frame_pulse_n) begin
			tx_idx_reg <= 3'h0;
			tx_slot_reg <= 6'h00;
		end else if (tx_step) begin
			tx_idx_reg <= tx_idx_reg + 3'h1;
			tx_slot_reg <= int_s ? next_slot(tx_idx_reg, tx_slot_reg) : 6'h00;
		end
	end

	always_ff @(posedge line_clock) begin
		if (!link_rst_n) begin
			pend_valid_reg <= 1'b0;
			req_seen_reg <= 1'b0;
			tx_ack_tgl <= 1'b0;
			pend_reg <= `HSHP_IDLE_BYTE;
			pend_cc_reg <= `HSHP_IDLE_BYTE;
			tx_shift_reg <= `HSHP_IDLE_BYTE;
			serial_line_out <= 1'b1;
		end else begin
			if (req_s != req_seen_reg) begin
				req_seen_reg <= req_s;
				pend_valid_reg <= 1'b1;
				pend_reg <= tx_data;
				pend_cc_reg <= cc_data;
			end
			if (tx_step && (tx_slot_ok || !int_s)) begin
				if (tx_idx_reg == 3'h0) begin
					// slot 1 carries the control channel byte
					if (int_s && tx_slot_reg == `HSHP_CC_SLOT) begin
						tx_shift_reg <= {pend_cc_reg[6:0], 1'b1};
						serial_line_out <= pend_cc_reg[7];
					end else begin
						tx_shift_reg <= pend_valid_reg ? {pend_reg[6:0], 1'b1} : `HSHP_IDLE_BYTE;
						serial_line_out <= pend_valid_reg ? pend_reg[7] : 1'b1;
						if (pend_valid_reg && req_s == req_seen_reg) begin
							pend_valid_reg <= 1'b0;
							tx_ack_tgl <= !tx_ack_tgl;
						end
					end
				end else begin
					tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
					serial_line_out <= tx_shift_reg[7];
				end
			end
		end
	end

	// drive only in data/control slots, or while the transmit gate is low
	always_ff @(posedge line_clock) begin
		if (!link_rst_n) begin
			serial_line_oe_n <= 1'b1;
		end else if (int_s) begin
			serial_line_oe_n <= !(tx_slot_ok && frame_pulse_n);
		end else begin
			serial_line_oe_n <= tx_clock_gate_n;
		end
	end

	// ----------------------------------------
	// receive, sampled on the falling edge
	// ----------------------------------------
	assign rx_slot_ok = rx_slot_reg <= `HSHP_LAST_SLOT;
	// external timing: gate high blocks the receive section
	assign rx_step = int_s ? (!dbl_s || rx_phase_reg) : !rx_clock_gate_n;

	always_ff @(negedge line_clock) begin
		if (!link_rst_n || !frame_pulse_n || !int_s) begin
			rx_phase_reg <= 1'b0;
		end else begin
			rx_phase_reg <= !rx_phase_reg;
		end
	end

	always_ff @(negedge line_clock) begin
		if (!link_rst_n) begin
			rx_idx_reg <= 3'h0;
			rx_slot_reg <= 6'h00;
			rx_shift_reg <= 8'h00;
			rx_tgl <= 1'b0;
			rx_data <= 8'h00;
			rx_cc_data <= 8'h00;
		end else if (int_s && !frame_pulse_n) begin
			rx_idx_reg <= 3'h0;
			rx_slot_reg <= 6'h00;
		end else if (rx_step) begin
			rx_idx_reg <= rx_idx_reg + 3'h1;
			rx_slot_reg <= int_s ? next_slot(rx_idx_reg, rx_slot_reg) : 6'h00;
			if (rx_slot_ok || !int_s) begin
				rx_shift_reg <= {rx_shift_reg[6:0], serial_line_in};
				if (rx_idx_reg == 3'h7) begin
					// slot 1 is control channel, the rest packet data
					if (int_s && rx_slot_reg == `HSHP_CC_SLOT) begin
						rx_cc_data <= {rx_shift_reg[6:0], serial_line_in};
					end else begin
						rx_data <= {rx_shift_reg[6:0], serial_line_in};
						rx_tgl <= !rx_tgl;
					end
				end
			end
		end
	end

endmodule : hshp_link

// *** hshp_top.sv ***
// Purpose: pin-level host port, watchdog, interrupt and serial side
// Assumes: host pins are asynchronous to clk and pass two flip-flops
// Notes: framing, crc and fifos sit outside; one byte each way here
`timescale 1ns/1ns
`include "hshp_defs.svh"

// Functional notes
// - external timing: transmit gate low drives serial out, high floats it
// - internal timing: both clock gate inputs are ignored
// - external timing: receive gate low enables receive, high blocks its clock
// - internal timing: packet data in slots 0,2,3,4, control channel slot 1
// - serial data both ways is plain non-return-to-zero
// - external timing: serial out changes on the line clock rising edge
// - external timing: serial in sampled on the line clock falling edge
// - watchdog output high, low on expiry or while reset is held
// - interrupt request pulled low only for a flagged and enabled source
// - register chosen by four select inputs qualified by strobe, select, direction
// - chip select must be low; accesses with it high are ignored
// - select and direction are latched and data moved only while strobe active
// - data bus driven when direction is read, an input when write
// - internal timing: line clock is bit rate or twice it, by rate bit
// - frame pulse starts each frame and clocks the watchdog
// - reset clears all registers, receive buffers and the watchdog; link transmit buffers load the idle byte ff
module hshp_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic line_clock,
	input wire logic frame_pulse_n,
	input wire logic tx_clock_gate_n,
	input wire logic rx_clock_gate_n,
	input wire logic serial_line_in,
	output logic serial_line_out,
	output logic serial_line_oe_n,
	output logic watchdog_out_n,
	output logic interrupt_request_out,
	output logic interrupt_request_oe_n,
	input wire logic [3:0] register_select,
	input wire logic chip_select_n,
	input wire logic enable_strobe,
	input wire logic read_write,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe_n
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [15:0] host_s;
	logic [3:0] sel_s;
	logic cs_n_s, e_s, rw_s, fp_s;
	logic [7:0] din_s;
	logic [1:0] back_s;
	logic ack_s, rx_tgl_s;

	hshp_sync #(.WIDTH(16)) u_host_sync (
		.clk(clk),
		.async_in({register_select, chip_select_n, enable_strobe, read_write, data_in,
			frame_pulse_n}),
		.sync_out(host_s)
	);
	assign {sel_s, cs_n_s, e_s, rw_s, din_s, fp_s} = host_s;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	hshp_pkg::hshp_acc_t acc_reg;
	hshp_pkg::hshp_addr_t addr_reg;
	logic rw_reg, e_prev_reg, fp_prev_reg;
	hshp_pkg::hshp_byte_t control_reg, rx_addr_reg, cc_tx_reg, timing_reg, int_en_reg;
	hshp_pkg::hshp_byte_t int_flag_reg, tx_data_reg, rx_data_reg, rx_cc_reg;
	hshp_pkg::hshp_byte_t wd_count_reg;
	logic tx_req_reg, tx_busy_reg, rx_full_reg, ack_seen_reg, rx_seen_reg;
	logic wd_armed_reg, wd_expired_reg;
	logic acc_start, wr_stb, rd_stb, fp_fall, tx_done_ev, rx_ev, wd_ev;
	hshp_pkg::hshp_byte_t rd_mux;
	logic [7:0] link_rx_data, link_rx_cc;
	logic link_ack_tgl, link_rx_tgl;

	// ----------------------------------------
	// host access
	// ----------------------------------------
	// an access starts on the strobe rising with chip select low
	assign acc_start = e_s && !e_prev_reg && !cs_n_s;
	assign wr_stb = acc_start && !rw_s;
	assign rd_stb = acc_start && rw_s;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			e_prev_reg <= 1'b0;
			fp_prev_reg <= 1'b1;
		end else begin
			e_prev_reg <= e_s;
			fp_prev_reg <= fp_s;
		end
	end

	// select and direction held from strobe rise to strobe fall
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			acc_reg <= hshp_pkg::HSHP_ACC_IDLE;
			addr_reg <= 4'h0;
			rw_reg <= 1'b0;
		end else begin
			case (acc_reg)
				hshp_pkg::HSHP_ACC_IDLE: begin
					if (acc_start) begin
						acc_reg <= hshp_pkg::HSHP_ACC_ACTIVE;
						addr_reg <= sel_s;
						rw_reg <= rw_s;
					end
				end
				hshp_pkg::HSHP_ACC_ACTIVE: begin
					if (!e_s || cs_n_s) begin
						acc_reg <= hshp_pkg::HSHP_ACC_DONE;
					end
				end
				hshp_pkg::HSHP_ACC_DONE: begin
					acc_reg <= hshp_pkg::HSHP_ACC_IDLE;
				end
				default: begin
					acc_reg <= hshp_pkg::HSHP_ACC_IDLE;
				end
			endcase
		end
	end

	always_comb begin
		case (sel_s)
			`HSHP_ADDR_FIFO_STAT: rd_mux = {6'h00, rx_full_reg, tx_busy_reg};
			`HSHP_ADDR_DATA: rd_mux = rx_data_reg;
			`HSHP_ADDR_CONTROL: rd_mux = control_reg;
			`HSHP_ADDR_RX_ADDR: rd_mux = rx_addr_reg;
			`HSHP_ADDR_CC_TX: rd_mux = cc_tx_reg;
			`HSHP_ADDR_TIMING: rd_mux = timing_reg;
			`HSHP_ADDR_FLAG_WDOG: rd_mux = int_flag_reg;
			`HSHP_ADDR_INT_EN: rd_mux = int_en_reg;
			`HSHP_ADDR_GEN_STAT: rd_mux = {5'h00, wd_expired_reg, wd_armed_reg,
				timing_reg[`HSHP_TIM_INTERNAL]};
			`HSHP_ADDR_CC_RX: rd_mux = rx_cc_reg;
			default: rd_mux = 8'h00;
		endcase
	end

	// read data driven only while a read access stands
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			data_out <= 8'h00;
			data_oe_n <= 1'b1;
		end else begin
			if (rd_stb) begin
				data_out <= rd_mux;
			end
			if (rd_stb) begin
				data_oe_n <= 1'b0;
			end else if (acc_reg != hshp_pkg::HSHP_ACC_ACTIVE || !e_s || cs_n_s || !rw_reg) begin
				data_oe_n <= 1'b1;
			end
		end
	end

	// write data taken at strobe rise while direction is write
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			control_reg <= `HSHP_REG_RESET;
			rx_addr_reg <= `HSHP_REG_RESET;
			cc_tx_reg <= `HSHP_REG_RESET;
			timing_reg <= `HSHP_REG_RESET;
			int_en_reg <= `HSHP_REG_RESET;
		end else if (wr_stb) begin
			case (sel_s)
				`HSHP_ADDR_CONTROL: control_reg <= din_s;
				`HSHP_ADDR_RX_ADDR: rx_addr_reg <= din_s;
				`HSHP_ADDR_CC_TX: cc_tx_reg <= din_s;
				`HSHP_ADDR_TIMING: timing_reg <= din_s;
				`HSHP_ADDR_INT_EN: int_en_reg <= din_s;
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// byte exchange with the link
	// ----------------------------------------
	hshp_sync #(.WIDTH(2)) u_back_sync (
		.clk(clk),
		.async_in({link_ack_tgl, link_rx_tgl}),
		.sync_out(back_s)
	);
	assign {ack_s, rx_tgl_s} = back_s;
	assign tx_done_ev = ack_s != ack_seen_reg;
	assign rx_ev = rx_tgl_s != rx_seen_reg;

	// transmit byte stays stable until the link acknowledges it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_data_reg <= `HSHP_REG_RESET;
			tx_req_reg <= 1'b0;
			tx_busy_reg <= 1'b0;
			ack_seen_reg <= 1'b0;
		end else begin
			ack_seen_reg <= ack_s;
			if (wr_stb && sel_s == `HSHP_ADDR_DATA && !tx_busy_reg) begin
				tx_data_reg <= din_s;
				tx_req_reg <= !tx_req_reg;
				tx_busy_reg <= 1'b1;
			end else if (tx_done_ev) begin
				tx_busy_reg <= 1'b0;
			end
		end
	end

	// new byte wins over a read that empties the holding register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_data_reg <= `HSHP_REG_RESET;
			rx_cc_reg <= `HSHP_REG_RESET;
			rx_full_reg <= 1'b0;
			rx_seen_reg <= 1'b0;
		end else begin
			rx_seen_reg <= rx_tgl_s;
			if (rx_ev) begin
				rx_cc_reg <= link_rx_cc;
				rx_data_reg <= link_rx_data;
				rx_full_reg <= 1'b1;
			end else if (rd_stb && sel_s == `HSHP_ADDR_DATA) begin
				rx_full_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// watchdog, counted on frame pulses
	// ----------------------------------------
	assign fp_fall = fp_prev_reg && !fp_s;
	assign wd_ev = wd_armed_reg && fp_fall && wd_count_reg == 8'h01;

	// a write reloads the count; zero disarms
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wd_count_reg <= 8'h00;
			wd_armed_reg <= 1'b0;
			wd_expired_reg <= 1'b0;
		end else if (wr_stb && sel_s == `HSHP_ADDR_FLAG_WDOG) begin
			wd_count_reg <= din_s;
			wd_armed_reg <= din_s != 8'h00;
			wd_expired_reg <= 1'b0;
		end else if (wd_ev) begin
			wd_count_reg <= 8'h00;
			wd_armed_reg <= 1'b0;
			wd_expired_reg <= 1'b1;
		end else if (wd_armed_reg && fp_fall) begin
			wd_count_reg <= wd_count_reg - 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			watchdog_out_n <= 1'b0;
		end else begin
			watchdog_out_n <= !(wd_expired_reg || wd_ev);
		end
	end

	// ----------------------------------------
	// interrupt flags and request
	// ----------------------------------------
	// reading the flag register clears it; a same-cycle event still sets
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			int_flag_reg <= `HSHP_REG_RESET;
		end else begin
			int_flag_reg <= (rd_stb && sel_s == `HSHP_ADDR_FLAG_WDOG) ? 8'h00 : int_flag_reg;
			int_flag_reg[`HSHP_FLG_TX_DONE] <= tx_done_ev ||
				(int_flag_reg[`HSHP_FLG_TX_DONE] && !(rd_stb && sel_s == `HSHP_ADDR_FLAG_WDOG));
			int_flag_reg[`HSHP_FLG_RX_BYTE] <= rx_ev ||
				(int_flag_reg[`HSHP_FLG_RX_BYTE] && !(rd_stb && sel_s == `HSHP_ADDR_FLAG_WDOG));
			int_flag_reg[`HSHP_FLG_WDOG] <= wd_ev ||
				(int_flag_reg[`HSHP_FLG_WDOG] && !(rd_stb && sel_s == `HSHP_ADDR_FLAG_WDOG));
		end
	end

	// open drain: pin only ever pulled low
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			interrupt_request_out <= 1'b0;
			interrupt_request_oe_n <= 1'b1;
		end else begin
			interrupt_request_out <= 1'b0;
			interrupt_request_oe_n <= ~|(int_flag_reg & int_en_reg);
		end
	end

	// ----------------------------------------
	// serial side
	// ----------------------------------------
	hshp_link u_link (
		.line_clock(line_clock),
		.rst_n(rst_n),
		.internal_mode(timing_reg[`HSHP_TIM_INTERNAL]),
		.line_clock_rate_sel(timing_reg[`HSHP_TIM_RATE_SEL]),
		.frame_pulse_n(frame_pulse_n),
		.tx_clock_gate_n(tx_clock_gate_n),
		.rx_clock_gate_n(rx_clock_gate_n),
		.serial_line_in(serial_line_in),
		.tx_req_tgl(tx_req_reg),
		.tx_data(tx_data_reg),
		.cc_data(cc_tx_reg),
		.tx_ack_tgl(link_ack_tgl),
		.rx_tgl(link_rx_tgl),
		.rx_data(link_rx_data),
		.rx_cc_data(link_rx_cc),
		.serial_line_out(serial_line_out),
		.serial_line_oe_n(serial_line_oe_n)
	);

endmodule : hshp_top

// *** hshp_properties.sv ***
// Purpose: port-level checks of hshp_top
// Assumes: every pin sampled on the system clock
// Notes: serial pins are tied to line clock edges seen from clk
`timescale 1ns/1ns
module hshp_properties (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic line_clock,
	input wire logic frame_pulse_n,
	input wire logic tx_clock_gate_n,
	input wire logic rx_clock_gate_n,
	input wire logic serial_line_in,
	input wire logic serial_line_out,
	input wire logic serial_line_oe_n,
	input wire logic watchdog_out_n,
	input wire logic interrupt_request_out,
	input wire logic interrupt_request_oe_n,
	input wire logic [3:0] register_select,
	input wire logic chip_select_n,
	input wire logic enable_strobe,
	input wire logic read_write,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic data_oe_n
);
	// ----------------------------------------
	// frame pulse age, saturating
	// ----------------------------------------
	logic [3:0] fp_age;
	always_ff @(posedge clk) begin
		if (!rst_n || !frame_pulse_n)
			fp_age <= 4'h0;
		else if (fp_age != 4'hf)
			fp_age <= fp_age + 4'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_WDOG_IN_RESET: assert property (disable iff (1'b0)
		!rst_n |=> !watchdog_out_n) else $error("watchdog high in reset");
	AST_IRQ_RESET: assert property (disable iff (1'b0)
		!rst_n |=> interrupt_request_oe_n && !interrupt_request_out) else $error("irq in reset");
	AST_WDOG_RELEASE: assert property (
		$rose(rst_n) |-> ##3 watchdog_out_n) else $error("watchdog low after reset");
	AST_NO_CS: assert property (
		chip_select_n [*5] |-> data_oe_n) else $error("bus driven without select");
	AST_NO_STROBE: assert property (
		!enable_strobe [*5] |-> data_oe_n) else $error("bus driven without strobe");
	AST_WRITE_NO_DRIVE: assert property (
		(enable_strobe && !read_write) [*5] |-> data_oe_n) else $error("bus driven on write");
	AST_READ_DRIVES: assert property (
		$rose(enable_strobe) && read_write && !chip_select_n |-> ##[2:5] !data_oe_n)
		else $error("read not answered");
	AST_TX_RISE: assert property (
		!$stable(serial_line_out) |-> $rose(line_clock)) else $error("serial out off edge");
	AST_OE_RISE: assert property (
		!$stable(serial_line_oe_n) |-> $rose(line_clock)) else $error("serial enable off edge");
	AST_WDOG_FRAME: assert property (
		$fell(watchdog_out_n) |-> fp_age < 4'hc) else $error("watchdog fell without frame");
	cover property (!data_oe_n);
	cover property (!interrupt_request_oe_n);
	cover property (!watchdog_out_n);
endmodule : hshp_properties

// *** hshp_serial_partner.sv ***
// Purpose: serial bus side model facing hshp_top
// Assumes: frame of 256 bits, gates change on falling edges
// Notes: released input line toggles so stale values never pass
`timescale 1ns/1ns
module hshp_serial_partner (
	input wire logic line_clock,
	input wire logic tx_en,
	input wire logic rx_en,
	input wire logic rx_level,
	input wire logic serial_line_out,
	input wire logic serial_line_oe_n,
	output logic frame_pulse_n,
	output logic tx_clock_gate_n,
	output logic rx_clock_gate_n,
	output logic serial_line_in,
	output logic [7:0] tx_win,
	output logic [8:0] oe_bits
);
	logic [7:0] bit_cnt;
	logic [8:0] oe_run;
	initial begin
		bit_cnt = 8'h00;
		oe_run = 9'h000;
		oe_bits = 9'h000;
		tx_win = 8'h00;
		frame_pulse_n = 1'b1;
		tx_clock_gate_n = 1'b1;
		rx_clock_gate_n = 1'b1;
		serial_line_in = 1'b1;
	end
	// frame pulse marks the last bit of each frame
	always @(negedge line_clock) begin
		bit_cnt <= bit_cnt + 8'h01;
		frame_pulse_n <= (bit_cnt != 8'hfe);
		tx_clock_gate_n <= !tx_en;
		rx_clock_gate_n <= !rx_en;
		if (!serial_line_oe_n)
			tx_win <= {tx_win[6:0], serial_line_out};
	end
	// data set up on the rising edge, taken by the device on the falling one
	always @(posedge line_clock) begin
		serial_line_in <= rx_en ? rx_level : ~serial_line_in;
		if (!frame_pulse_n) begin
			oe_bits <= oe_run;
			oe_run <= 9'h000;
		end else if (!serial_line_oe_n)
			oe_run <= oe_run + 9'h001;
	end
endmodule : hshp_serial_partner

// *** hdlc_serial_and_host_pins_tb.sv ***
// Purpose: self-checking bench of hshp_top
// Assumes: host pins driven on clk, serial side by the partner
// Notes: reads queue their expected byte for the bus monitor
`timescale 1ns/1ns
`include "hshp_defs.svh"
module hdlc_serial_and_host_pins_tb;
	logic clk, rst_n, line_clock, tx_en, rx_en, rx_level, chip_select_n, enable_strobe;
	logic read_write, serial_line_out, serial_line_oe_n, watchdog_out_n, interrupt_request_out;
	logic interrupt_request_oe_n, data_oe_n, frame_pulse_n, tx_clock_gate_n, rx_clock_gate_n;
	logic serial_line_in, prev_oe;
	logic [3:0] register_select;
	logic [7:0] data_in, data_out, tx_win, v;
	logic [8:0] oe_bits;
	logic [7:0] exp_q[$];
	integer seed, n_mismatch, total_checks, i;
	hshp_top DUT (.clk(clk), .rst_n(rst_n), .line_clock(line_clock),
		.frame_pulse_n(frame_pulse_n), .tx_clock_gate_n(tx_clock_gate_n),
		.rx_clock_gate_n(rx_clock_gate_n), .serial_line_in(serial_line_in),
		.serial_line_out(serial_line_out), .serial_line_oe_n(serial_line_oe_n),
		.watchdog_out_n(watchdog_out_n), .interrupt_request_out(interrupt_request_out),
		.interrupt_request_oe_n(interrupt_request_oe_n), .register_select(register_select),
		.chip_select_n(chip_select_n), .enable_strobe(enable_strobe), .read_write(read_write),
		.data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));
	hshp_serial_partner u_far (.line_clock(line_clock), .tx_en(tx_en), .rx_en(rx_en),
		.rx_level(rx_level), .serial_line_out(serial_line_out),
		.serial_line_oe_n(serial_line_oe_n), .frame_pulse_n(frame_pulse_n),
		.tx_clock_gate_n(tx_clock_gate_n), .rx_clock_gate_n(rx_clock_gate_n),
		.serial_line_in(serial_line_in), .tx_win(tx_win), .oe_bits(oe_bits));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		line_clock = 1'b0;
		#13;
		forever #40 line_clock = ~line_clock;
	end
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		total_checks = total_checks + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// one host access; strobe held well past the answer, then a gap of six clocks
	task automatic acc(input logic csn, input logic rd, input logic [3:0] a,
		input logic [7:0] d);
		@(posedge clk);
		chip_select_n <= csn;
		read_write <= rd;
		register_select <= a;
		data_in <= d;
		enable_strobe <= 1'b1;
		if (rd && !csn)
			exp_q.push_back(d);
		repeat (7) @(posedge clk);
		enable_strobe <= 1'b0;
		chip_select_n <= 1'b1;
		repeat (6) @(posedge clk);
	endtask : acc
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run
	always @(negedge clk) begin
		if (data_oe_n === 1'b0 && prev_oe !== 1'b0) begin
			if (exp_q.size() == 0)
				chk("unexpected drive", 8'h00, 8'hff);
			else
				chk("data_out", exp_q.pop_front(), data_out);
		end
		prev_oe = data_oe_n;
	end
	initial begin
		#400000;
		n_mismatch = n_mismatch + 1;
		complete_run();
	end
	initial begin
		seed = 59890;
		n_mismatch = 0;
		total_checks = 0;
		prev_oe = 1'b1;
		{rst_n, tx_en, rx_en, rx_level, enable_strobe, read_write} = 6'h00;
		chip_select_n = 1'b1;
		register_select = 4'h0;
		data_in = 8'h00;
		// reset spans several line clocks so the link side sees it too
		repeat (40) @(posedge clk);
		chk("watchdog_out_n", 8'h00, {7'h00, watchdog_out_n});
		chk("serial_line_oe_n", 8'h01, {7'h00, serial_line_oe_n});
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk("watchdog_out_n", 8'h01, {7'h00, watchdog_out_n});
		$display("test reset done");
		for (i = 2; i < 8; i = i + 1) begin
			if (i == 5 || i == 6)
				continue;
			v = 8'($random(seed));
			acc(1'b0, 1'b0, i[3:0], v);
			acc(1'b1, 1'b0, i[3:0], ~v);
			acc(1'b0, 1'b1, i[3:0], v);
		end
		acc(1'b0, 1'b0, `HSHP_ADDR_INT_EN, 8'h00);
		acc(1'b0, 1'b0, `HSHP_ADDR_GEN_STAT, 8'hff);
		acc(1'b0, 1'b1, `HSHP_ADDR_GEN_STAT, 8'h00);
		acc(1'b0, 1'b1, 4'ha, 8'h00);
		$display("test registers done");
		tx_en <= 1'b1;
		rx_en <= 1'b1;
		rx_level <= 1'b1;
		acc(1'b0, 1'b0, `HSHP_ADDR_DATA, 8'ha5);
		for (i = 0; i < 3000 && tx_win !== 8'ha5; i = i + 1)
			@(posedge clk);
		chk("tx_win", 8'ha5, tx_win);
		repeat (40) @(posedge clk);
		acc(1'b0, 1'b1, `HSHP_ADDR_FLAG_WDOG, 8'h03);
		acc(1'b0, 1'b1, `HSHP_ADDR_FIFO_STAT, 8'h02);
		acc(1'b0, 1'b1, `HSHP_ADDR_DATA, 8'hff);
		tx_en <= 1'b0;
		rx_en <= 1'b0;
		repeat (40) @(posedge clk);
		chk("serial_line_oe_n", 8'h01, {7'h00, serial_line_oe_n});
		$display("test external link done");
		acc(1'b0, 1'b0, `HSHP_ADDR_INT_EN, 8'h04);
		chk("interrupt_request_oe_n", 8'h01, {7'h00, interrupt_request_oe_n});
		acc(1'b0, 1'b0, `HSHP_ADDR_FLAG_WDOG, 8'h02);
		for (i = 0; i < 8000 && watchdog_out_n !== 1'b0; i = i + 1)
			@(posedge clk);
		chk("watchdog_out_n", 8'h00, {7'h00, watchdog_out_n});
		repeat (4) @(posedge clk);
		chk("interrupt_request_oe_n", 8'h00, {7'h00, interrupt_request_oe_n});
		chk("interrupt_request_out", 8'h00, {7'h00, interrupt_request_out});
		acc(1'b0, 1'b0, `HSHP_ADDR_INT_EN, 8'h00);
		chk("interrupt_request_oe_n", 8'h01, {7'h00, interrupt_request_oe_n});
		$display("test watchdog done");
		acc(1'b0, 1'b0, `HSHP_ADDR_TIMING, 8'h01);
		for (i = 0; i < 6000 && serial_line_oe_n !== 1'b0; i = i + 1)
			@(posedge clk);
		chk("serial_line_oe_n", 8'h00, {7'h00, serial_line_oe_n});
		repeat (4300) @(posedge clk);
		chk("oe_bits", 8'h01, {7'h00, oe_bits inside {[9'd38:9'd41]}});
		acc(1'b0, 1'b0, `HSHP_ADDR_TIMING, 8'h03);
		repeat (4300) @(posedge clk);
		chk("oe_bits", 8'h01, {7'h00, oe_bits inside {[9'd78:9'd81]}});
		chk("queue", 8'h00, 8'(exp_q.size()));
		$display("test internal frame done");
		complete_run();
	end
endmodule : hdlc_serial_and_host_pins_tb
bind hshp_top hshp_properties u_props (.clk(clk), .rst_n(rst_n), .line_clock(line_clock),
	.frame_pulse_n(frame_pulse_n), .tx_clock_gate_n(tx_clock_gate_n),
	.rx_clock_gate_n(rx_clock_gate_n), .serial_line_in(serial_line_in),
	.serial_line_out(serial_line_out), .serial_line_oe_n(serial_line_oe_n),
	.watchdog_out_n(watchdog_out_n), .interrupt_request_out(interrupt_request_out),
	.interrupt_request_oe_n(interrupt_request_oe_n), .register_select(register_select),
	.chip_select_n(chip_select_n), .enable_strobe(enable_strobe), .read_write(read_write),
	.data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));
